/* rtl/eac_ctrl.sv */
// Top of the EEPROM access controller: control, address and data registers.
// Assumes the CPU core drives the register port on i_clk and honours o_cpu_stall.
//
// Operation
// R1: Data register carries write and read bytes.
// R2: Mode field picks erase, write or both.
// R3: Mode field frozen while write strobe set.
// R4: Reset clears mode unless programming.
// R5: Ready interrupt while enabled and strobe clear.
// R6: No ready interrupt during write or self-program.
// R7: Write starts only within four-cycle arm window.
// R8: Strobe without arm has no effect.
// R9: Arm bit self-clears after four cycles.
// R10: Software arms then strobes within four cycles.
// R11: No EEPROM write during Flash self-programming.
// R12: Hardware clears strobe when programming ends.
// R13: Write strobe stalls CPU two cycles.
// R14: Read strobe fetches byte, stalls four cycles.
// R15: Writes block reads and address changes.
// R16: Write time counted on calibrated oscillator.
// R17: Software keeps interrupts off during sequence.
// R18: Software polls strobe before reading.
// R19: Ten-bit address selects one of 1024.
// R20: Unarmed strobe leaves strobe bit zero.
`timescale 1ns/1ps
`include "eac_defs.svh"

module eac_ctrl (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_ce,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    input  wire logic        i_global_irq_en,
    input  wire logic        i_self_program_active,
    input  wire logic        i_rc_clk_pin,
    output logic             o_cpu_stall,
    output logic             o_ready_irq,
    output eac_pkg::eac_prog_req_type o_prog,
    output logic      [9:0]  o_nvm_rd_addr,
    input  wire logic [7:0]  i_nvm_rd_data
);

    // ************************************************************
    // Register state
    // ************************************************************

    logic [7:0]  nvm_data_reg_r;
    logic [9:0]  nvm_address_reg_r;
    logic [1:0]  program_action_select_r;
    logic        ready_irq_enable_r;
    logic        master_write_arm_r;
    logic        write_strobe_r;
    logic [2:0]  arm_cnt_r;
    logic [2:0]  stall_cnt_r;
    logic [7:0]  rdata_r;
    logic [2:0]  rc_sync_r;
    logic        rc_level_r;
    eac_pkg::eac_state_type state_r;
    eac_pkg::eac_prog_req_type prog_r;

    // ************************************************************
    // Decoding
    // ************************************************************

    wire sel_ctrl    = (i_reg_addr == `EAC_OFS_CTRL);
    wire sel_data    = (i_reg_addr == `EAC_OFS_DATA);
    wire sel_addr_lo = (i_reg_addr == `EAC_OFS_ADDR_LO);
    wire sel_addr_hi = (i_reg_addr == `EAC_OFS_ADDR_HI);
    wire wr_ctrl     = i_reg_wr && sel_ctrl;
    wire busy        = write_strobe_r;
    wire arm_set     = wr_ctrl && i_reg_wdata[`EAC_BIT_ARM] && !i_reg_wdata[`EAC_BIT_WSTB];
    wire wstb_req    = wr_ctrl && i_reg_wdata[`EAC_BIT_WSTB];
    // A write launches only inside the arm window, idle, and no self-program.
    wire launch      = wstb_req && master_write_arm_r && !busy      // [R7] [R8] [R20]
                       && !i_self_program_active;                   // [R11]
    wire rd_launch   = wr_ctrl && i_reg_wdata[`EAC_BIT_RSTB] && !busy; // [R15]
    wire timer_busy;
    wire timer_done;
    // The timer keeps its count through a reset while a write is in progress; the synchroniser is reset, so no ticks arrive.
    wire timer_nrst  = i_nrst || write_strobe_r;

    // Calibrated oscillator pin sampled through three flip-flops.
    wire rc_agree    = (rc_sync_r[1] == rc_sync_r[2]);
    wire rc_tick     = rc_agree && rc_sync_r[2] && !rc_level_r;

    // ************************************************************
    // Programming timer
    // ************************************************************

    eac_prog_timer u_timer (
        .i_clk     (i_clk),
        .i_nrst    (timer_nrst),
        .i_ce      (i_ce),
        .i_start   (launch),
        .i_rc_tick (rc_tick),
        .i_limit   (`EAC_WR_RC_CYCLES), // [R16]
        .o_busy    (timer_busy),
        .o_done    (timer_done)
    );

    // ************************************************************
    // Oscillator synchroniser
    // ************************************************************

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rc_sync_r  <= 3'h0;
            rc_level_r <= 1'b0;
        end else if (i_ce) begin
            rc_sync_r <= {rc_sync_r[1:0], i_rc_clk_pin};
            if (rc_agree) begin
                rc_level_r <= rc_sync_r[2];
            end
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ready_irq_enable_r <= 1'b0;
            master_write_arm_r <= 1'b0;
            arm_cnt_r          <= 3'h0;
            if (busy) begin
                program_action_select_r <= program_action_select_r;
            end else begin
                program_action_select_r <= `EAC_RST_PM; // [R4]
            end
        end else if (i_ce) begin
            if (wr_ctrl) begin
                ready_irq_enable_r <= i_reg_wdata[`EAC_BIT_RIE];
                if (!busy) begin
                    program_action_select_r <= i_reg_wdata[`EAC_BIT_PM_HI:`EAC_BIT_PM_LO]; // [R2] [R3]
                end
            end
            if (arm_set) begin
                master_write_arm_r <= 1'b1;
                arm_cnt_r          <= `EAC_ARM_CYCLES - 3'h1;
            end else if (launch || arm_cnt_r == 3'h0) begin
                master_write_arm_r <= 1'b0; // [R9]
            end else begin
                arm_cnt_r <= arm_cnt_r - 3'h1;
            end
        end
    end

    // ************************************************************
    // Write strobe and programming sequencer
    // ************************************************************

    // Reset leaves the strobe and sequencer alone so a running write completes.
    always_ff @(posedge i_clk) begin
        if (i_nrst || busy) begin
            if (i_ce) begin
                prog_r.req <= 1'b0;
                case (state_r)
                    eac_pkg::EAC_IDLE: begin
                        if (launch) begin
                            write_strobe_r <= 1'b1;
                            state_r        <= eac_pkg::EAC_PROG;
                            prog_r.req     <= 1'b1;
                            prog_r.action  <= program_action_select_r; // [R2]
                            prog_r.addr    <= nvm_address_reg_r;
                            prog_r.data    <= nvm_data_reg_r;          // [R1]
                        end
                    end
                    eac_pkg::EAC_PROG: begin
                        if (timer_done) begin
                            state_r <= eac_pkg::EAC_DONE;
                        end
                    end
                    eac_pkg::EAC_DONE: begin
                        write_strobe_r <= 1'b0; // [R12]
                        state_r        <= eac_pkg::EAC_IDLE;
                    end
                    default: begin
                        state_r <= eac_pkg::EAC_IDLE;
                    end
                endcase
            end
        end else begin
            write_strobe_r <= 1'b0;
            state_r        <= eac_pkg::EAC_IDLE;
            prog_r         <= '0;
        end
    end

    // ************************************************************
    // Address, data and stall
    // ************************************************************

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            nvm_data_reg_r <= `EAC_RST_DATA;
            stall_cnt_r    <= 3'h0;
        end else if (i_ce) begin
            if (rd_launch) begin
                nvm_data_reg_r <= i_nvm_rd_data; // [R14] [R1]
            end else if (i_reg_wr && sel_data) begin
                nvm_data_reg_r <= i_reg_wdata;
            end
            if (launch) begin
                stall_cnt_r <= `EAC_WSTALL_CYC; // [R13]
            end else if (rd_launch) begin
                stall_cnt_r <= `EAC_RSTALL_CYC; // [R14]
            end else if (stall_cnt_r != 3'h0) begin
                stall_cnt_r <= stall_cnt_r - 3'h1;
            end
        end
    end

    // The address has no reset value; software loads it first.
    always_ff @(posedge i_clk) begin
        if (i_ce && i_nrst && !busy) begin
            if (i_reg_wr && sel_addr_lo) begin
                nvm_address_reg_r[7:0] <= i_reg_wdata; // [R15] [R19]
            end
            if (i_reg_wr && sel_addr_hi) begin
                nvm_address_reg_r[9:8] <= i_reg_wdata[1:0];
            end
        end
    end

    // ************************************************************
    // Read mux
    // ************************************************************

    wire [7:0] ctrl_view = {2'h0, program_action_select_r, ready_irq_enable_r,
                            master_write_arm_r, write_strobe_r, 1'b0};
    wire [7:0] rd_mux = sel_ctrl    ? ctrl_view :
                        sel_data    ? nvm_data_reg_r :
                        sel_addr_lo ? nvm_address_reg_r[7:0] :
                        sel_addr_hi ? {6'h00, nvm_address_reg_r[9:8]} : 8'h00;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rdata_r <= 8'h00;
        end else if (i_ce && i_reg_rd) begin
            rdata_r <= rd_mux;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    assign o_reg_rdata   = rdata_r;
    assign o_cpu_stall   = (stall_cnt_r != 3'h0);
    assign o_ready_irq   = ready_irq_enable_r && i_global_irq_en && !write_strobe_r // [R5]
                           && !i_self_program_active && !timer_busy;            // [R6]
    assign o_prog        = prog_r;
    assign o_nvm_rd_addr = nvm_address_reg_r;

    // ************************************************************
    // Checks
    // ************************************************************

    property p_arm_clear;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && arm_set) ##1 (i_ce && !launch && !arm_set) [*4] |=> !master_write_arm_r;
    endproperty
    a_arm_clear: assert property (p_arm_clear) else $error("Arm bit not cleared."); // [R9]

    property p_no_unarmed;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && wstb_req && !master_write_arm_r && !busy) |=> !write_strobe_r;
    endproperty
    a_no_unarmed: assert property (p_no_unarmed) else $error("Unarmed strobe set busy."); // [R8]

    property p_launch;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && launch) |=> (write_strobe_r && prog_r.req);
    endproperty
    a_launch: assert property (p_launch) else $error("Armed strobe did not launch."); // [R7]

    property p_pm_frozen;
        @(posedge i_clk) disable iff (!i_nrst)
        (write_strobe_r && $past(write_strobe_r)) |-> $stable(program_action_select_r);
    endproperty
    a_pm_frozen: assert property (p_pm_frozen) else $error("Mode changed while busy."); // [R3]

    property p_irq;
        @(posedge i_clk) disable iff (!i_nrst)
        write_strobe_r |-> !o_ready_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt during write."); // [R6]

    property p_wstall;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && launch) |=> o_cpu_stall ##1 (o_cpu_stall || !i_ce) ##1 (!o_cpu_stall || !i_ce);
    endproperty
    a_wstall: assert property (p_wstall) else $error("Write stall wrong."); // [R13]

    property p_rd;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && rd_launch) |=> (nvm_data_reg_r == $past(i_nvm_rd_data)) && o_cpu_stall;
    endproperty
    a_rd: assert property (p_rd) else $error("Read fetch wrong."); // [R14]

    property p_addr_hold;
        @(posedge i_clk) disable iff (!i_nrst)
        (busy && $past(busy)) |-> $stable(nvm_address_reg_r);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("Address moved while busy."); // [R15]

    property p_self_prog;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_self_program_active && !busy) |=> !write_strobe_r;
    endproperty
    a_self_prog: assert property (p_self_prog) else $error("Write during self-program."); // [R11]

    property p_pm_reset;
        @(posedge i_clk)
        (!i_nrst && !busy) |=> (program_action_select_r == `EAC_RST_PM);
    endproperty
    a_pm_reset: assert property (p_pm_reset) else $error("Mode not cleared by reset."); // [R4]

    property p_pm_reset_hold;
        @(posedge i_clk)
        (!i_nrst && busy) |=> $stable(program_action_select_r);
    endproperty
    a_pm_reset_hold: assert property (p_pm_reset_hold) else $error("Mode lost in reset."); // [R4]

    property p_strobe_clear;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && write_strobe_r && timer_done) ##1 i_ce |=> !write_strobe_r;
    endproperty
    a_strobe_clear: assert property (p_strobe_clear) else $error("Strobe not cleared."); // [R12]

    property p_read_blocked;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && wr_ctrl && i_reg_wdata[`EAC_BIT_RSTB] && busy) |=> $stable(nvm_data_reg_r);
    endproperty
    a_read_blocked: assert property (p_read_blocked) else $error("Read while busy."); // [R15]

    property p_irq_ready;
        @(posedge i_clk) disable iff (!i_nrst)
        (ready_irq_enable_r && i_global_irq_en && !write_strobe_r
         && state_r == eac_pkg::EAC_IDLE && !i_self_program_active) |-> o_ready_irq;
    endproperty
    a_irq_ready: assert property (p_irq_ready) else $error("Ready interrupt missing."); // [R5]

    property p_self_prog_irq;
        @(posedge i_clk) disable iff (!i_nrst)
        i_self_program_active |-> !o_ready_irq;
    endproperty
    a_self_prog_irq: assert property (p_self_prog_irq) else $error("Interrupt in self-program."); // [R6]

    property p_rd_stall;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && rd_launch && !launch) ##1 (i_ce && !launch && !rd_launch) [*4] |=> !o_cpu_stall;
    endproperty
    a_rd_stall: assert property (p_rd_stall) else $error("Read stall too long."); // [R14]

    property p_addr_lo;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && !busy && i_reg_wr && sel_addr_lo)
        |=> (nvm_address_reg_r[7:0] == $past(i_reg_wdata));
    endproperty
    a_addr_lo: assert property (p_addr_lo) else $error("Address low byte not loaded."); // [R19]

endmodule

/* rtl/eac_defs.svh */
// Offsets, field positions, reset values and timing counts of the EEPROM access controller.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef EAC_DEFS_SVH
`define EAC_DEFS_SVH

// Data-space byte offsets of the three registers.
`define EAC_OFS_DATA     8'h40
`define EAC_OFS_ADDR_LO  8'h41
`define EAC_OFS_ADDR_HI  8'h42
`define EAC_OFS_CTRL     8'h3F

// Field positions within the control register.
`define EAC_BIT_RSTB     0
`define EAC_BIT_WSTB     1
`define EAC_BIT_ARM      2
`define EAC_BIT_RIE      3
`define EAC_BIT_PM_LO    4
`define EAC_BIT_PM_HI    5

// Reset values.
`define EAC_RST_CTRL     8'h00
`define EAC_RST_DATA     8'h00
`define EAC_RST_PM       2'h0

// Program action encodings.
`define EAC_PM_ATOMIC    2'h0
`define EAC_PM_ERASE     2'h1
`define EAC_PM_WRITE     2'h2

// Arm window and CPU stall lengths in system clock cycles.
`define EAC_ARM_CYCLES   3'h4
`define EAC_WSTALL_CYC   3'h2
`define EAC_RSTALL_CYC   3'h4

// Write time in calibrated oscillator cycles, and its typical figures in microseconds.
`define EAC_WR_RC_CYCLES 16'h6700
`define EAC_T_WRITE_US   3300
`define EAC_T_ATOMIC_US  3400
`define EAC_T_SPLIT_US   1800

`endif

/* rtl/eac_pkg.sv */
// Types shared by the EEPROM access controller files.
// Assumes the constants header eac_defs.svh is available alongside.
package eac_pkg;

    typedef enum logic [1:0] {
        EAC_IDLE = 2'h0,
        EAC_PROG = 2'h1,
        EAC_DONE = 2'h3
    } eac_state_type;

    typedef struct packed {
        logic       req;
        logic [1:0] action;
        logic [9:0] addr;
        logic [7:0] data;
    } eac_prog_req_type;

endpackage

/* rtl/eac_prog_timer.sv */
// Programming timer counting calibrated oscillator ticks.
// Assumes the tick input is already synchronous to i_clk as a one-cycle pulse.
`timescale 1ns/1ps
`include "eac_defs.svh"

module eac_prog_timer (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_ce,
    input  wire logic        i_start,
    input  wire logic        i_rc_tick,
    input  wire logic [15:0] i_limit,
    output logic             o_busy,
    output logic             o_done
);

    logic [15:0] cnt_r;
    logic        busy_r;
    logic        done_r;
    wire         last_tick = busy_r && i_rc_tick && (cnt_r == i_limit - 16'h0001);

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            cnt_r  <= 16'h0000;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else if (i_ce) begin
            done_r <= last_tick;
            if (i_start && !busy_r) begin
                cnt_r  <= 16'h0000;
                busy_r <= 1'b1;
            end else if (last_tick) begin
                busy_r <= 1'b0;
            end else if (busy_r && i_rc_tick) begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    assign o_busy = busy_r;
    assign o_done = done_r;

endmodule

/* test/eac_nvm_model.sv */
// Behavioural byte array and free-running calibrated oscillator beside the controller.
// Assumes the controller launches programming with one-cycle req pulses on i_clk.
`timescale 1ns/1ps

module eac_nvm_model #(
    parameter int RC_HALF_NS = 80
) (
    input  wire logic                      i_clk,
    input  eac_pkg::eac_prog_req_type      i_prog,
    input  wire logic [9:0]                i_rd_addr,
    output logic      [7:0]                o_rd_data,
    output logic                           o_rc_clk
);
    logic [7:0] mem [0:1023];

    // ****************************************
    // Array contents and oscillator.
    // ****************************************
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = i[7:0] ^ {i[9:8], 6'h15};
        end
        o_rc_clk = 1'b0;
        forever #RC_HALF_NS o_rc_clk = ~o_rc_clk;
    end

    always @(posedge i_clk) begin
        if (i_prog.req === 1'b1) begin
            case (i_prog.action)
                2'h0:    mem[i_prog.addr] <= i_prog.data;
                2'h1:    mem[i_prog.addr] <= 8'hFF;
                default: mem[i_prog.addr] <= mem[i_prog.addr] & i_prog.data;
            endcase
        end
    end

    assign o_rd_data = mem[i_rd_addr];
endmodule

/* test/eac_tb_top.sv */
// Self-checking bench for the EEPROM access controller.
// Assumes eac_pkg is compiled first and eac_defs.svh is on the include path.
`timescale 1ns/1ps
`include "eac_defs.svh"

module eac_tb_top;
    logic        i_clk, i_nrst, i_ce, i_reg_wr, i_reg_rd, i_global_irq_en;
    logic        i_self_program_active, rc, o_cpu_stall, o_ready_irq;
    logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, i_nvm_rd_data, b, dat;
    logic [9:0]  o_nvm_rd_addr, ad;
    logic [31:0] seed;
    int          failures, n_tests, n, t_s;
    int          cyc = 0, n_req = 0, n_stall = 0, t0 = 0;
    eac_pkg::eac_prog_req_type o_prog, seen;

    eac_ctrl u_eac_ctrl (.i_clk, .i_nrst, .i_ce, .i_reg_addr, .i_reg_wr, .i_reg_rd,
        .i_reg_wdata, .o_reg_rdata, .i_global_irq_en, .i_self_program_active,
        .i_rc_clk_pin(rc), .o_cpu_stall, .o_ready_irq, .o_prog, .o_nvm_rd_addr,
        .i_nvm_rd_data);

    eac_nvm_model u_eac_nvm_model (.i_clk, .i_prog(o_prog), .i_rd_addr(o_nvm_rd_addr),
        .o_rd_data(i_nvm_rd_data), .o_rc_clk(rc));

    // ****************************************
    // Helpers.
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction

    function automatic logic [7:0] init_b(input logic [9:0] x);
        return x[7:0] ^ {x[9:8], 6'h15};
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Bus access that honours the CPU stall and leaves an idle cycle behind it.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        repeat (6) if (o_cpu_stall === 1'b1) @(negedge i_clk);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_clk);
        i_reg_wr = 1'b0;
        @(negedge i_clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        repeat (6) if (o_cpu_stall === 1'b1) @(negedge i_clk);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(negedge i_clk);
        i_reg_rd = 1'b0;
        d = o_reg_rdata;
        @(negedge i_clk);
    endtask

    task automatic set_addr(input logic [9:0] x);
        wr(`EAC_OFS_ADDR_LO, x[7:0]);
        wr(`EAC_OFS_ADDR_HI, {6'h00, x[9:8]});
    endtask

    // ****************************************
    // Clock, monitors and hang limit.
    // ****************************************
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (o_cpu_stall === 1'b1) n_stall <= n_stall + 1;
        if (o_prog.req === 1'b1) begin
            n_req <= n_req + 1;
            seen <= o_prog;
            t0 <= cyc;
        end
    end

    initial begin
        #(40 * 120000);
        failures++;
        final_report();
    end

    // ****************************************
    // Scenarios.
    // ****************************************
    initial begin
        {i_nrst, i_reg_wr, i_reg_rd, i_global_irq_en, i_self_program_active} = 5'h00;
        {i_reg_addr, i_reg_wdata, failures, n_tests} = '0;
        i_ce = 1'b1;
        seed = 32'h186B;
        repeat (10) @(negedge i_clk);
        i_nrst = 1'b1;
        rd(`EAC_OFS_CTRL, b);
        chk("ctrl_reset", 8'h00, b);
        rd(`EAC_OFS_DATA, b);
        chk("data_reset", 8'h00, b);
        for (int k = 0; k < 5; k++) begin
            seed = lfsr(seed);
            ad = (k == 0) ? 10'h000 : (k == 1) ? 10'h3FF : seed[9:0];
            set_addr(ad);
            chk("nvm_addr", ad, o_nvm_rd_addr);
            t_s = n_stall;
            wr(`EAC_OFS_CTRL, 8'h01);
            rd(`EAC_OFS_DATA, b);
            chk("read_stall", 4, n_stall - t_s);
            chk("read_data", init_b(ad), b);
        end
        seed = lfsr(seed);
        wr(`EAC_OFS_DATA, seed[7:0]);
        rd(`EAC_OFS_DATA, b);
        chk("data_rw", seed[7:0], b);
        i_ce = 1'b0;
        wr(`EAC_OFS_DATA, ~seed[7:0]);
        i_ce = 1'b1;
        rd(`EAC_OFS_DATA, b);
        chk("data_frozen", seed[7:0], b);
        i_global_irq_en = 1'b1;
        for (int m = 0; m < 3; m++) begin
            dat = {2'h0, m[1:0], 4'h8};
            wr(`EAC_OFS_CTRL, dat);
            rd(`EAC_OFS_CTRL, b);
            chk("ctrl_mode", dat, b);
        end
        chk("irq_idle", 1, o_ready_irq);
        i_self_program_active = 1'b1;
        @(negedge i_clk);
        chk("irq_spm", 0, o_ready_irq);
        wr(`EAC_OFS_CTRL, 8'h04);
        wr(`EAC_OFS_CTRL, 8'h02);
        rd(`EAC_OFS_CTRL, b);
        chk("strobe_spm", 0, b[1]);
        i_self_program_active = 1'b0;
        wr(`EAC_OFS_CTRL, 8'h02);
        rd(`EAC_OFS_CTRL, b);
        chk("strobe_unarmed", 0, b[1]);
        wr(`EAC_OFS_CTRL, 8'h04);
        rd(`EAC_OFS_CTRL, b);
        chk("arm_set", 8'h04, b);
        repeat (4) @(negedge i_clk);
        rd(`EAC_OFS_CTRL, b);
        chk("arm_expired", 8'h00, b);
        wr(`EAC_OFS_CTRL, 8'h02);
        chk("no_launch", 0, n_req);
        // Full write with interrupts kept off through the arm sequence.
        i_global_irq_en = 1'b0;
        seed = lfsr(seed);
        ad = seed[17:8];
        dat = seed[7:0];
        set_addr(ad);
        wr(`EAC_OFS_DATA, dat);
        t_s = n_stall;
        wr(`EAC_OFS_CTRL, 8'h2C);
        wr(`EAC_OFS_CTRL, 8'h2A);
        chk("launch", 1, n_req);
        chk("launch_fields", {2'h2, ad}, {seen.action, seen.addr});
        chk("launch_data", dat, seen.data);
        wr(`EAC_OFS_CTRL, 8'h3B);
        wr(`EAC_OFS_ADDR_LO, ~ad[7:0]);
        rd(`EAC_OFS_CTRL, b);
        chk("ctrl_busy", 8'h2A, b);
        chk("write_stall", 2, n_stall - t_s);
        chk("addr_locked", ad, o_nvm_rd_addr);
        rd(`EAC_OFS_DATA, b);
        chk("read_blocked", dat, b);
        i_global_irq_en = 1'b1;
        @(negedge i_clk);
        chk("irq_busy", 0, o_ready_irq);
        n = 0;
        while (o_ready_irq !== 1'b1 && n < 110000) begin
            @(negedge i_clk);
            n++;
        end
        chk("write_done", 1, o_ready_irq);
        n = cyc - t0;
        chk("write_time", 1, n >= 105465 && n <= 105480);
        rd(`EAC_OFS_CTRL, b);
        chk("ctrl_done", 8'h28, b);
        chk("irq_level", 1, o_ready_irq);
        i_global_irq_en = 1'b0;
        @(negedge i_clk);
        chk("irq_masked", 0, o_ready_irq);
        wr(`EAC_OFS_CTRL, 8'h01);
        rd(`EAC_OFS_DATA, b);
        chk("written_byte", init_b(ad) & dat, b);
        wr(`EAC_OFS_CTRL, 8'h18);
        i_nrst = 1'b0;
        @(negedge i_clk);
        i_nrst = 1'b1;
        rd(`EAC_OFS_CTRL, b);
        chk("ctrl_rereset", 8'h00, b);
        final_report();
    end
endmodule
